// *** src/pdr_latch8.sv ***
// eight-bit serial-in latch with storage register and open-drain outputs
// Notes on behaviour
// - eight-stage shift register plus equal storage register
// - shift and storage use independent clocks
// - low master clear empties both registers
// - shift clock rise moves bits, takes serial input
// - storage clock rise copies whole shift register
// - cascade output follows shift clock and master clear only
// - cascade carries last stage for chaining
// - tied clocks: storage lags shift by one
// - enable low: outputs follow storage bits
// - enable high: all outputs off
// - enable changes never touch either register
`timescale 1ns/1ps
`default_nettype none

module pdr_latch8 (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // serial side, from the host
   input wire logic serial_data_in,
   input wire logic shift_clock,
   input wire logic storage_clock,
   input wire logic master_clear_n,
   input wire logic output_enable_n,
   // serial cascade towards the next device
   output logic serial_cascade_out,
   // open-drain parallel outputs
   input wire logic [pdr_pkg::PDR_WIDTH-1:0] parallel_outputs_in,
   output logic [pdr_pkg::PDR_WIDTH-1:0] parallel_outputs_out,
   output logic [pdr_pkg::PDR_WIDTH-1:0] parallel_outputs_oe_n
);
   import pdr_pkg::*;

   // raw pins gathered into one group
   pdr_pins_t pins_raw;
   // pins after the synchroniser
   pdr_pins_t pins;
   // one-cycle pulse on a shift clock rise
   logic shift_rise;
   // one-cycle pulse on a storage clock rise
   logic store_rise;
   // core state and its next value
   pdr_core_st_t st_reg;
   pdr_core_st_t st_next;
   // clear is not asserted on the synchronised pin
   logic run_ok;

   // group the asynchronous pins so they cross together
   always_comb begin
      pins_raw = PDR_PINS_RST;
      pins_raw.serial_data = serial_data_in;
      pins_raw.shift_clk = shift_clock;
      pins_raw.store_clk = storage_clock;
      pins_raw.clear_n = master_clear_n;
      pins_raw.out_en_n = output_enable_n;
   end

   // every pin passes two flip-flops before use
   pdr_sync u_sync (
      .clk(clk),
      .srst(srst),
      .pins_raw(pins_raw),
      .pins_safe(pins)
   );

   // edge finder on the shift clock
   pdr_edge u_shift_edge (
      .clk(clk),
      .srst(srst),
      .level(pins.shift_clk),
      .rise(shift_rise)
   );

   // separate edge finder on the storage clock
   pdr_edge u_store_edge (
      .clk(clk),
      .srst(srst),
      .level(pins.store_clk),
      .rise(store_rise)
   );

   // synchronised clear pin; low stops every register update
   assign run_ok = pins.clear_n;

   // next state of both registers and of all pins
   always_comb begin
      st_next = st_reg;
      // open-drain pins only ever pull low
      st_next.level = PDR_PULL_LOW;
      if (!run_ok) begin
         // clear holds both registers empty, clocks ignored
         st_next.shift = PDR_ZERO_BITS;
         st_next.store = PDR_ZERO_BITS;
      end else begin
         // shift register moves on its own clock
         if (shift_rise) begin
            st_next.shift = {st_reg.shift[PDR_LAST-1:0], pins.serial_data};
         end
         // storage copies the old shift contents
         if (store_rise) begin
            st_next.store = st_reg.shift;
         end
      end
      // cascade pin shows the last stage
      st_next.cascade = st_next.shift[PDR_LAST];
      // enable high switches every output off
      if (pins.out_en_n) begin
         st_next.drive_n = PDR_ALL_OFF;
      end else begin
         // a stored one switches its output on
         st_next.drive_n = ~st_next.store;
      end
   end

   // register the core; the enable pin never enters shift or store
   always_ff @(posedge clk) begin
      if (srst) begin
         st_reg <= PDR_CORE_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // pins come straight from flip-flops
   assign serial_cascade_out = st_reg.cascade;
   assign parallel_outputs_out = st_reg.level;
   assign parallel_outputs_oe_n = st_reg.drive_n;

   // pin readback is not needed by the latch itself
   logic [PDR_WIDTH-1:0] pin_readback;
   assign pin_readback = parallel_outputs_in;

   // checks on the core, all on clk

   // both registers are emptied while clear is low
   a_clear_both:
   assert property (@(posedge clk) disable iff (srst)
      !run_ok |=> (st_reg.shift == PDR_ZERO_BITS) && (st_reg.store == PDR_ZERO_BITS))
   else $error("clear did not empty both registers");

   // a shift edge moves the bits and takes the serial input
   a_shift_moves:
   assert property (@(posedge clk) disable iff (srst)
      (run_ok && shift_rise)
      |=> st_reg.shift == {$past(st_reg.shift[PDR_LAST-1:0]), $past(pins.serial_data)})
   else $error("shift edge did not move the shift register");

   // shift register holds when only the storage clock is active
   a_shift_holds:
   assert property (@(posedge clk) disable iff (srst)
      (run_ok && !shift_rise) |=> $stable(st_reg.shift))
   else $error("shift register changed without a shift edge");

   // a storage edge copies all eight bits at once
   a_store_copy:
   assert property (@(posedge clk) disable iff (srst)
      (run_ok && store_rise) |=> st_reg.store == $past(st_reg.shift))
   else $error("storage edge did not copy the shift register");

   // with tied clocks storage lags the shift register by one edge
   a_tied_clocks:
   assert property (@(posedge clk) disable iff (srst)
      (run_ok && shift_rise && store_rise)
      |=> (st_reg.store == $past(st_reg.shift))
          && (st_reg.shift[PDR_LAST:1] == st_reg.store[PDR_LAST-1:0]))
   else $error("tied clocks did not leave storage one edge behind");

   // outside a clear the cascade pin moves only on a shift edge, to the old stage six
   a_cascade_step:
   assert property (@(posedge clk) disable iff (srst)
      (run_ok && shift_rise) |=> serial_cascade_out == $past(st_reg.shift[PDR_LAST-1]))
   else $error("cascade did not take the next stage on a shift edge");

   // the cascade pin stays put between shift edges
   a_cascade_hold:
   assert property (@(posedge clk) disable iff (srst)
      (run_ok && !shift_rise) |=> $stable(serial_cascade_out))
   else $error("cascade changed without a shift edge");

   // enable high turns every output off within one cycle
   a_outputs_off:
   assert property (@(posedge clk) disable iff (srst)
      pins.out_en_n |=> parallel_outputs_oe_n == PDR_ALL_OFF)
   else $error("outputs not off while enable is high");

   // enable low maps each stored one to a driven output
   a_outputs_map:
   assert property (@(posedge clk) disable iff (srst)
      !pins.out_en_n |=> parallel_outputs_oe_n == ~st_reg.store)
   else $error("outputs do not follow the storage register");

   // a driven open-drain pin always pulls low
   a_pull_low:
   assert property (@(posedge clk) disable iff (srst)
      (parallel_outputs_oe_n != PDR_ALL_OFF) |-> parallel_outputs_out == PDR_PULL_LOW)
   else $error("open-drain output driven high");

   // toggling the enable leaves both registers alone
   a_enable_quiet:
   assert property (@(posedge clk) disable iff (srst)
      ($changed(pins.out_en_n) && run_ok && !shift_rise && !store_rise)
      |=> $stable(st_reg.shift) && $stable(st_reg.store))
   else $error("enable change disturbed a register");

   // the storage register changes only on a storage edge or a clear
   a_store_holds:
   assert property (@(posedge clk) disable iff (srst)
      (run_ok && !store_rise) |=> $stable(st_reg.store))
   else $error("storage register changed without a storage edge");

   // clear also empties the cascade pin
   a_clear_cascade:
   assert property (@(posedge clk) disable iff (srst)
      !run_ok |=> !serial_cascade_out)
   else $error("clear left the cascade pin high");

   // the cascade pin always mirrors the last shift stage
   a_cascade_last:
   assert property (@(posedge clk) disable iff (srst)
      serial_cascade_out == st_reg.shift[PDR_LAST])
   else $error("cascade pin differs from the last shift stage");

   // a lone shift edge leaves the storage register alone
   a_store_apart:
   assert property (@(posedge clk) disable iff (srst)
      (run_ok && shift_rise && !store_rise)
      |=> $stable(st_reg.store))
   else $error("shift edge alone changed the storage register");

   // a lone storage edge leaves the shift register alone
   a_shift_apart:
   assert property (@(posedge clk) disable iff (srst)
      (run_ok && store_rise && !shift_rise)
      |=> $stable(st_reg.shift))
   else $error("storage edge alone changed the shift register");

   // clock edges during a clear are swallowed
   a_clear_blocks:
   assert property (@(posedge clk) disable iff (srst)
      (!run_ok && (shift_rise || store_rise))
      |=> (st_reg.shift == PDR_ZERO_BITS) && (st_reg.store == PDR_ZERO_BITS))
   else $error("clock edge acted while clear was low");

   // an emptied storage register switches every output off
   a_clear_outputs:
   assert property (@(posedge clk) disable iff (srst)
      !run_ok |=> parallel_outputs_oe_n == PDR_ALL_OFF)
   else $error("output still driven during clear");

   // with outputs off a storage edge still loads, but nothing is driven
   a_off_loads:
   assert property (@(posedge clk) disable iff (srst)
      (pins.out_en_n && run_ok && store_rise)
      |=> (parallel_outputs_oe_n == PDR_ALL_OFF) && (st_reg.store == $past(st_reg.shift)))
   else $error("storage edge with outputs off misbehaved");

   // an output is driven only for a stored one
   a_drive_ones:
   assert property (@(posedge clk) disable iff (srst)
      (~parallel_outputs_oe_n & ~st_reg.store) == PDR_ZERO_BITS)
   else $error("output driven for a stored zero");

   // outputs hold while enable and storage are both quiet
   a_outputs_hold:
   assert property (@(posedge clk) disable iff (srst)
      (run_ok && !store_rise && $stable(pins.out_en_n))
      |=> $stable(parallel_outputs_oe_n))
   else $error("outputs changed with enable and storage quiet");

   // a shift clock rise lasts exactly one cycle
   a_shift_pulse:
   assert property (@(posedge clk) disable iff (srst)
      shift_rise |=> !shift_rise)
   else $error("shift edge pulse longer than one cycle");

   // a storage clock rise lasts exactly one cycle
   a_store_pulse:
   assert property (@(posedge clk) disable iff (srst)
      store_rise |=> !store_rise)
   else $error("storage edge pulse longer than one cycle");

   // the first stage takes the serial input on a shift edge
   a_first_stage:
   assert property (@(posedge clk) disable iff (srst)
      (run_ok && shift_rise) |=> st_reg.shift[0] == $past(pins.serial_data))
   else $error("first stage missed the serial input");

   // with tied clocks the cascade pin leads the top storage bit by one stage
   a_tied_cascade:
   assert property (@(posedge clk) disable iff (srst)
      (run_ok && shift_rise && store_rise)
      |=> serial_cascade_out == st_reg.store[PDR_LAST-1])
   else $error("tied clocks put the cascade pin out of step");

   // enable changes never touch the cascade pin
   a_enable_cascade:
   assert property (@(posedge clk) disable iff (srst)
      ($changed(pins.out_en_n) && run_ok && !shift_rise) |=> $stable(serial_cascade_out))
   else $error("enable change disturbed the cascade pin");

endmodule

`default_nettype wire

// *** inc/pdr_pkg.sv ***
// shared widths, reset values and state types of the power driver latch
`default_nettype none

package pdr_pkg;

   // width of the shift and storage registers
   localparam int unsigned PDR_WIDTH = 8;
   // index of the last shift stage, feeding the cascade pin
   localparam int unsigned PDR_LAST = PDR_WIDTH - 1;

   // all bits clear, used for both registers after a clear
   localparam logic [PDR_WIDTH-1:0] PDR_ZERO_BITS = 8'h00;
   // all open-drain enables high: every output switched off
   localparam logic [PDR_WIDTH-1:0] PDR_ALL_OFF = 8'hff;
   // level driven on an open-drain pin when it is switched on
   localparam logic [PDR_WIDTH-1:0] PDR_PULL_LOW = 8'h00;

   // raw pin levels that belong together, sampled as one group
   typedef struct packed {
      logic serial_data; // serial data input
      logic shift_clk;   // shift register clock
      logic store_clk;   // storage register clock
      logic clear_n;     // master clear, active low
      logic out_en_n;    // output enable, active low
   } pdr_pins_t;

   // idle pin levels assumed while srst is high
   localparam pdr_pins_t PDR_PINS_RST = '{
      serial_data: 1'h0,
      shift_clk: 1'h0,
      store_clk: 1'h0,
      clear_n: 1'h1,
      out_en_n: 1'h1
   };

   // state of the two-stage pin synchroniser
   typedef struct packed {
      pdr_pins_t s1; // first stage, read by s2 only
      pdr_pins_t s2; // second stage, safe to use
   } pdr_sync_st_t;

   localparam pdr_sync_st_t PDR_SYNC_RST = '{s1: PDR_PINS_RST, s2: PDR_PINS_RST};

   // state of one rising-edge finder
   typedef struct packed {
      logic prev; // level seen one cycle earlier
   } pdr_edge_st_t;

   localparam pdr_edge_st_t PDR_EDGE_RST = '{prev: 1'h0};

   // whole state of the latch core
   typedef struct packed {
      logic [PDR_WIDTH-1:0] shift;   // serial shift register
      logic [PDR_WIDTH-1:0] store;   // parallel storage register
      logic cascade;                 // serial cascade pin level
      logic [PDR_WIDTH-1:0] drive_n; // open-drain enables, low = on
      logic [PDR_WIDTH-1:0] level;   // open-drain pin levels
   } pdr_core_st_t;

   localparam pdr_core_st_t PDR_CORE_RST = '{
      shift: PDR_ZERO_BITS,
      store: PDR_ZERO_BITS,
      cascade: 1'h0,
      drive_n: PDR_ALL_OFF,
      level: PDR_PULL_LOW
   };

endpackage

`default_nettype wire

// *** src/pdr_sync.sv ***
// two flip-flop synchroniser for the group of control pins
`timescale 1ns/1ps
`default_nettype none

module pdr_sync (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // raw pin group from outside the clock domain
   input wire pdr_pkg::pdr_pins_t pins_raw,
   // same group after two flip-flops
   output var pdr_pkg::pdr_pins_t pins_safe
);
   import pdr_pkg::*;

   pdr_sync_st_t st_reg; // current stages
   pdr_sync_st_t st_next; // next stages

   // stage one takes the pins, stage two takes stage one only
   always_comb begin
      st_next = st_reg;
      st_next.s1 = pins_raw;
      st_next.s2 = st_reg.s1;
   end

   // register the stages, idle levels under reset
   always_ff @(posedge clk) begin
      if (srst) begin
         st_reg <= PDR_SYNC_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // only the second stage leaves the module
   assign pins_safe = st_reg.s2;

endmodule

`default_nettype wire

// *** src/pdr_edge.sv ***
// rising edge finder for one synchronised clock pin
`timescale 1ns/1ps
`default_nettype none

module pdr_edge (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // synchronised level to watch
   input wire logic level,
   // one-cycle pulse on a low-to-high change
   output logic rise
);
   import pdr_pkg::*;

   pdr_edge_st_t st_reg; // previous level
   pdr_edge_st_t st_next; // next previous level

   // remember the level for the next cycle
   always_comb begin
      st_next = st_reg;
      st_next.prev = level;
   end

   // register the history, low under reset
   always_ff @(posedge clk) begin
      if (srst) begin
         st_reg <= PDR_EDGE_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // high now, low one cycle ago
   assign rise = level & ~st_reg.prev;

endmodule

`default_nettype wire

// *** tb/pdr_host_model.sv ***
// host model driving the serial, clock, clear and enable pins of the latch
`timescale 1ns/1ps
`default_nettype none

module pdr_host_model (
   // bench clock, paces the link
   input wire logic clk,
   // pins towards the latch
   output logic serial_data_in,
   output logic shift_clock,
   output logic storage_clock,
   output logic master_clear_n,
   output logic output_enable_n
);
   // idle pins at time zero, clocks standing low
   initial begin
      serial_data_in = 1'h0;
      shift_clock = 1'h0;
      storage_clock = 1'h0;
      master_clear_n = 1'h1;
      output_enable_n = 1'h1;
   end

   // one link half period: 16 ns of 4 ns cycles
   task automatic half();
      repeat (4) @(posedge clk);
      #1;
   endtask

   // one rise and fall on the chosen clock pins
   task automatic pulse(input logic sh, input logic st);
      shift_clock = sh;
      storage_clock = st;
      half();
      // data hold over: show a changed level, not the old bit
      serial_data_in = ~serial_data_in;
      shift_clock = 1'h0;
      storage_clock = 1'h0;
      half();
   endtask

   // one serial bit, set up a half period before the rise
   task automatic send_bit(input logic d, input logic st);
      serial_data_in = d;
      half();
      pulse(1'h1, st);
   endtask

   // whole byte, highest output first, then one storage rise
   task automatic send_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         send_bit(b[i], 1'h0);
      end
      pulse(1'h0, 1'h1);
   endtask

   // level pins: clear and enable, held long enough to act
   task automatic set_pins(input logic clr_n, input logic en_n);
      master_clear_n = clr_n;
      output_enable_n = en_n;
      half();
      half();
   endtask
endmodule
`default_nettype wire

// *** tb/tb_serial_to_parallel_latch_8bit.sv ***
// self-checking bench of the eight-bit serial latch
`timescale 1ns/1ps
`default_nettype none

module tb_serial_to_parallel_latch_8bit;
   import pdr_pkg::*;
   logic clk = 1'h0;
   logic srst = 1'h1;
   wire logic sdi, shc, stc, clr_n, en_n; // pins from the host model
   logic cascade;
   logic [7:0] out_val, oe_n;
   logic [7:0] exp_shift = 8'h00; // expected shift register
   logic [7:0] exp_store = 8'h00; // expected storage register
   logic exp_en_n = 1'h1; // expected enable level
   int errors = 0;
   int check_count = 0;
   int cycles = 0;
   wire logic [7:0] pin_lvl = oe_n | out_val; // pull-up where released

   always #2 clk = ~clk;

   pdr_host_model i_host (.clk(clk), .serial_data_in(sdi), .shift_clock(shc),
      .storage_clock(stc), .master_clear_n(clr_n), .output_enable_n(en_n));

   pdr_latch8 i_dut (.clk(clk), .srst(srst), .serial_data_in(sdi), .shift_clock(shc),
      .storage_clock(stc), .master_clear_n(clr_n), .output_enable_n(en_n),
      .serial_cascade_out(cascade), .parallel_outputs_in(pin_lvl),
      .parallel_outputs_out(out_val), .parallel_outputs_oe_n(oe_n));

   // compare and count
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // all outputs against the expected registers
   task automatic outs();
      check(oe_n, exp_en_n ? PDR_ALL_OFF : ~exp_store);
      check(out_val, PDR_PULL_LOW);
      check({7'h00, cascade}, {7'h00, exp_shift[PDR_LAST]});
   endtask

   // shift one byte bit by bit, then latch it
   task automatic t_shift_store(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         i_host.send_bit(b[i], 1'h0);
         exp_shift = {exp_shift[6:0], b[i]};
         outs();
      end
      i_host.pulse(1'h0, 1'h1);
      exp_store = exp_shift;
      outs();
   endtask

   // enable off and on again, registers kept
   task automatic t_enable();
      exp_en_n = 1'h1;
      i_host.set_pins(1'h1, 1'h1);
      outs();
      exp_en_n = 1'h0;
      i_host.set_pins(1'h1, 1'h0);
      outs();
   endtask

   // both clocks in one pulse: storage lags by one edge
   task automatic t_tied(input logic d);
      i_host.send_bit(d, 1'h1);
      exp_store = exp_shift;
      exp_shift = {exp_shift[6:0], d};
      outs();
   endtask

   // clear empties both registers and blocks clock edges
   task automatic t_clear();
      i_host.set_pins(1'h0, 1'h0);
      exp_shift = PDR_ZERO_BITS;
      exp_store = PDR_ZERO_BITS;
      outs();
      i_host.send_bit(1'h1, 1'h1);
      outs();
      i_host.set_pins(1'h1, 1'h0);
      i_host.pulse(1'h0, 1'h1);
      outs();
   endtask

   // counts and verdict
   task automatic end_of_test();
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         end_of_test();
      end
   end

   // main sequence
   initial begin
      repeat (5) @(posedge clk);
      #1;
      srst = 1'h0;
      repeat (4) @(posedge clk);
      #1;
      outs();
      exp_en_n = 1'h0;
      i_host.set_pins(1'h1, 1'h0);
      t_shift_store(8'ha5);
      t_enable();
      t_shift_store(8'h3c);
      t_tied(1'h1);
      t_tied(1'h0);
      t_clear();
      i_host.send_byte(8'h81);
      exp_shift = 8'h81;
      exp_store = 8'h81;
      outs();
      end_of_test();
   end
endmodule
`default_nettype wire
